// ### shared/dsl_pkg.sv
// Shared constants for both ends of the data/strobe two-bit link.
package dsl_pkg;
  // System clock and link clock periods in nanoseconds.
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  // System cycles per half period of the serial bit clock.
  localparam int SER_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // Write clock periods that the link reset is held low, then high before data.
  localparam int RESET_HOLD_CLKS = 3;
  localparam int RESET_SETUP_CLKS = 3;
  // Bit positions of a transmit pair word.
  localparam int PAIR_DE = 0;
  localparam int PAIR_DO = 1;
  localparam int PAIR_SE = 2;
  localparam int PAIR_SO = 3;
  localparam int PAIR_W = 4;
  // Synchroniser positions inside the device.
  localparam int SY_SCLK = 0;
  localparam int SY_WCLK = 1;
  localparam int SY_RSTB = 2;
  localparam int SY_OE = 3;
  localparam int SY_LCL = 4;
  localparam int SY_FAR = 5;
  localparam int SY_PAIR = 6;
  localparam int SY_DP = 10;
  localparam int SY_DN = 11;
  localparam int SY_SP = 12;
  localparam int SY_SN = 13;
  localparam int SY_W = 14;
  // Register map of the controller, byte addresses on APB.
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  // Control register fields and reset value.
  localparam int CTRL_DRIVE = 0;
  localparam int CTRL_LOCAL = 1;
  localparam int CTRL_FAR = 2;
  localparam int CTRL_RESTART = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status register fields.
  localparam int ST_READY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_SEEN = 3;
  // Depth of the transmit FIFO.
  localparam int TX_FIFO_DEPTH = 8;
endpackage

// ### shared/dsl_link_if.sv
`timescale 1ns/1ns
// Parallel side of the link between the controller and the two-bit PHY.
interface dsl_link_if;
  import dsl_pkg::*;
  logic serial_bit_clock; // Full-rate transmit clock from the controller.
  logic parallel_write_clock; // Half-rate write clock from the controller.
  logic link_reset_b; // Active-low PHY reset.
  logic line_drive_enable; // Enables the differential line drivers.
  logic local_loop_select; // Receive outputs take the transmit inputs.
  logic far_loop_select; // Line outputs reproduce the line inputs.
  logic [PAIR_W-1:0] tx_pair; // Even/odd data and strobe bits.
  logic rx_even_bit_out; // Bit taken on the recovered clock rise.
  logic rx_odd_bit_out; // Bit taken on the recovered clock fall.
  logic recovered_receive_clock; // Data xor strobe.
  // PHY end: takes clocks and pairs, returns received bits.
  modport phy (
    input serial_bit_clock, parallel_write_clock, link_reset_b, line_drive_enable,
    input local_loop_select, far_loop_select, tx_pair,
    output rx_even_bit_out, rx_odd_bit_out, recovered_receive_clock
  );
  // Controller end: makes clocks and pairs, reads received bits.
  modport ctl (
    output serial_bit_clock, parallel_write_clock, link_reset_b, line_drive_enable,
    output local_loop_select, far_loop_select, tx_pair,
    input rx_even_bit_out, rx_odd_bit_out, recovered_receive_clock
  );
endinterface

// ### hdl/dsl_phy.sv
`timescale 1ns/1ns
// How it works
// - Drive enable high drives lines, else released.
// - Even output holds bit from recovered rise.
// - Odd output holds bit from recovered fall.
// - Reset held low three write clocks.
// - Reset high three clocks before data.
// - Serial clock runs twice write clock rate.
// - Both clocks share one source, any phase.
// - Line bits change on serial clock rises.
// - Pairs captured on write clock rises.
// - Even strobe bit goes out first.
// - Odd strobe bit goes out second.
// - Even data bit goes out first.
// - Local loop feeds receiver from transmit pairs.
// - Far loop copies line inputs to outputs.
module dsl_phy
  import dsl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  dsl_link_if.phy link,
  input wire logic line_data_in_p,
  input wire logic line_data_in_n,
  input wire logic line_strobe_in_p,
  input wire logic line_strobe_in_n,
  output logic line_data_out_p,
  output logic line_data_out_n,
  output logic line_strobe_out_p,
  output logic line_strobe_out_n,
  output logic line_oe_out
);

  // Turns a differential pair into a level; an undriven or shorted pair reads high.
  function automatic logic diff_level(input logic p, input logic n);
    diff_level = (p != n) ? p : 1'b1;
  endfunction

  // Every pin comes from another domain and passes two flip-flops.
  logic [SY_W-1:0] sync1_q;
  logic [SY_W-1:0] sync2_q;
  logic [SY_W-1:0] pins;

  // Previous levels of the synchronised clocks for edge detection.
  logic sclk_prev_q;
  logic wclk_prev_q;

  // Captured pair, even-first flag and the serialised bits.
  logic [PAIR_W-1:0] pair_q, pair_d;
  logic even_next_q, even_next_d;
  logic tx_d_q, tx_d_d;
  logic tx_s_q, tx_s_d;

  // Registered line output levels and enable.
  logic out_d_q, out_d_d;
  logic out_s_q, out_s_d;
  logic oe_q, oe_d;

  // Receive side: recovered clock and the two captured bits.
  logic rclk_q, rclk_d;
  logic even_q, even_d;
  logic odd_q, odd_d;

  // Decoded events and levels, from second-stage flip-flops and the serialiser registers.
  logic s_rise;
  logic w_rise;
  logic phy_run;
  logic line_d;
  logic line_s;
  logic src_d;
  logic src_s;
  logic [PAIR_W-1:0] src_pair;
  logic src_even;

  // Gather the raw pins in synchroniser order.
  assign pins = {line_strobe_in_n, line_strobe_in_p, line_data_in_n, line_data_in_p,
                 link.tx_pair, link.far_loop_select, link.local_loop_select,
                 link.line_drive_enable, link.link_reset_b,
                 link.parallel_write_clock, link.serial_bit_clock};

  // Two-stage synchroniser; only the second stage feeds logic.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sclk_prev_q <= 1'b0;
      wclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[SY_SCLK];
      wclk_prev_q <= sync2_q[SY_WCLK];
    end
  end

  // Serial clock rising edge moves the line bits.
  assign s_rise = sync2_q[SY_SCLK] & ~sclk_prev_q;
  // Write clock rising edge takes a new pair.
  assign w_rise = sync2_q[SY_WCLK] & ~wclk_prev_q;
  // The link reset pin gates every data path except the far loop while low.
  assign phy_run = sync2_q[SY_RSTB];
  // Differential inputs turned into levels.
  assign line_d = diff_level(sync2_q[SY_DP], sync2_q[SY_DN]);
  assign line_s = diff_level(sync2_q[SY_SP], sync2_q[SY_SN]);

  // A pair arriving with a serial edge in the same cycle is used at once, so
  // no phase between the two clocks loses a bit.
  assign src_pair = w_rise ? sync2_q[SY_PAIR +: PAIR_W] : pair_q;
  assign src_even = w_rise | even_next_q;

  // Serialiser next state: even bits on the first serial edge after a
  // capture, odd bits on the next one.
  always_comb begin
    pair_d = pair_q;
    even_next_d = even_next_q;
    tx_d_d = tx_d_q;
    tx_s_d = tx_s_q;
    if (!phy_run) begin
      // Held in reset: nothing is serialised.
      pair_d = '0;
      even_next_d = 1'b0;
      tx_d_d = 1'b0;
      tx_s_d = 1'b0;
    end else begin
      if (w_rise) begin
        pair_d = src_pair;
        even_next_d = 1'b1;
      end
      if (s_rise) begin
        // One data and one strobe bit leave on every serial clock.
        if (src_even) begin
          tx_d_d = src_pair[PAIR_DE];
          tx_s_d = src_pair[PAIR_SE];
          even_next_d = 1'b0;
        end else begin
          tx_d_d = src_pair[PAIR_DO];
          tx_s_d = src_pair[PAIR_SO];
        end
      end
    end
  end

  // Serialiser registers.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pair_q <= '0;
      even_next_q <= 1'b0;
      tx_d_q <= 1'b0;
      tx_s_q <= 1'b0;
    end else begin
      pair_q <= pair_d;
      even_next_q <= even_next_d;
      tx_d_q <= tx_d_d;
      tx_s_q <= tx_s_d;
    end
  end

  // Line output selection. Far loop copies the line inputs even in reset;
  // otherwise the serialised bits go out, or zero while in reset.
  always_comb begin
    oe_d = sync2_q[SY_OE];
    if (sync2_q[SY_FAR]) begin
      out_d_d = line_d;
      out_s_d = line_s;
    end else begin
      out_d_d = tx_d_q & phy_run;
      out_s_d = tx_s_q & phy_run;
    end
  end

  // Line output registers.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_d_q <= 1'b0;
      out_s_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      out_d_q <= out_d_d;
      out_s_q <= out_s_d;
      oe_q <= oe_d;
    end
  end

  // Complementary line pins; the enable tells the wire whether they drive.
  assign line_data_out_p = out_d_q;
  assign line_data_out_n = ~out_d_q;
  assign line_strobe_out_p = out_s_q;
  assign line_strobe_out_n = ~out_s_q;
  assign line_oe_out = oe_q;

  // Receive source: transmit stream in local loop, line inputs otherwise.
  assign src_d = sync2_q[SY_LCL] ? tx_d_q : line_d;
  assign src_s = sync2_q[SY_LCL] ? tx_s_q : line_s;

  // Receiver next state: the clock is data xor strobe, each of its edges
  // samples one data bit.
  always_comb begin
    rclk_d = src_d ^ src_s;
    even_d = even_q;
    odd_d = odd_q;
    if (!phy_run) begin
      // In reset the receive outputs rest low.
      rclk_d = 1'b0;
      even_d = 1'b0;
      odd_d = 1'b0;
    end else if (rclk_d && !rclk_q) begin
      even_d = src_d;
    end else if (!rclk_d && rclk_q) begin
      odd_d = src_d;
    end
  end

  // Receiver registers.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rclk_q <= 1'b0;
      even_q <= 1'b0;
      odd_q <= 1'b0;
    end else begin
      rclk_q <= rclk_d;
      even_q <= even_d;
      odd_q <= odd_d;
    end
  end

  // Receive pins all come straight from flip-flops.
  assign link.recovered_receive_clock = rclk_q;
  assign link.rx_even_bit_out = even_q;
  assign link.rx_odd_bit_out = odd_q;

endmodule

// ### hdl/dsl_ctl.sv
`timescale 1ns/1ns
// Transmit FIFO with valid and ready on both sides.
module dsl_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Depth must be a power of two so the pointers wrap on their own.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Full and empty come from the fill count.
  // Ready while fewer than DEPTH words are held; an empty FIFO must take a word.
  assign wr_ready_out = (cnt_q < (AW + 1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out = mem_q[rp_q];
  assign push = wr_valid_in & wr_ready_out;
  assign pop = rd_valid_out & rd_ready_in;

  // Pointer and count update.
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Pointer registers and storage.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage is written without reset.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end
endmodule

// Controller end: makes the link clocks and reset, feeds pairs, collects bits.
module dsl_ctl
  import dsl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  dsl_link_if.ctl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PAIR_W-1:0] tx_pair_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [1:0] rx_pair_out,
  output logic rx_valid_out
);
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SETUP = 2'b01,
    ST_RUN = 2'b10
  } dsl_state_e;

  // Divider and generated clocks.
  logic [7:0] div_q, div_d;
  logic sclk_q, sclk_d, wclk_q, wclk_d;
  logic tick, w_rise, w_fall;
  // Reset sequencer.
  dsl_state_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  // Registers and outputs.
  logic [2:0] ctrl_q, ctrl_d;
  logic seen_q, seen_d;
  logic [1:0] rxp_q, rxp_d;
  logic rxv_q, rxv_d;
  logic [PAIR_W-1:0] pair_q, pair_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  // Receive synchroniser: rclk, even, odd.
  logic [2:0] rs1_q, rs2_q;
  logic rclk_prev_q;
  logic rclk_fall;
  // FIFO read side.
  logic [PAIR_W-1:0] f_data;
  logic f_valid, f_pop;
  logic wr_acc, restart;

  // The transmit FIFO; its ready stalls the user stream.
  dsl_fifo #(.WIDTH(PAIR_W), .DEPTH(TX_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_data_in(tx_pair_in),
    .wr_valid_in(tx_valid_in),
    .wr_ready_out(tx_ready_out),
    .rd_data_out(f_data),
    .rd_valid_out(f_valid),
    .rd_ready_in(f_pop)
  );

  // Write clock toggles with each serial rise, giving exactly half rate.
  assign tick = (div_q == 8'(SER_HALF_CYC - 1));
  assign w_rise = tick & ~sclk_q & ~wclk_q;
  assign w_fall = tick & ~sclk_q & wclk_q;
  // A pair leaves the FIFO at each write clock fall while running.
  assign f_pop = w_fall & f_valid & (st_q == ST_RUN);
  assign rclk_fall = ~rs2_q[0] & rclk_prev_q;
  assign wr_acc = psel & penable & pwrite;
  assign restart = wr_acc && paddr == REG_CTRL && pwdata[CTRL_RESTART];

  // Clock divider, reset sequencer, pair output and registers.
  always_comb begin
    div_d = tick ? 8'h00 : div_q + 8'h01;
    sclk_d = tick ? ~sclk_q : sclk_q;
    wclk_d = (tick && !sclk_q) ? ~wclk_q : wclk_q;
    st_d = st_q;
    cnt_d = cnt_q;
    pair_d = pair_q;
    case (st_q)
      ST_HOLD: begin
        // Reset low for full write periods before release.
        if (w_rise) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'(RESET_HOLD_CLKS)) begin
            st_d = ST_SETUP;
            cnt_d = 3'h0;
          end
        end
      end
      ST_SETUP: begin
        // Reset high, no data yet.
        if (w_rise) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'(RESET_SETUP_CLKS)) begin
            st_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        // Pairs change on the write fall, stable at the PHY's rise.
        if (w_fall) begin
          pair_d = f_valid ? f_data : '0;
        end
      end
      default: st_d = ST_HOLD;
    endcase
    if (restart) begin
      st_d = ST_HOLD;
      cnt_d = 3'h0;
      pair_d = '0;
    end
    ctrl_d = ctrl_q;
    if (wr_acc && paddr == REG_CTRL) begin
      ctrl_d = pwdata[2:0];
    end
    // A received pair completes on each recovered clock fall.
    rxv_d = rclk_fall;
    rxp_d = rclk_fall ? {rs2_q[2], rs2_q[1]} : rxp_q;
    // Sticky seen flag: the set wins over a write-one clear.
    seen_d = seen_q;
    if (wr_acc && paddr == REG_STATUS && pwdata[ST_SEEN]) begin
      seen_d = 1'b0;
    end
    if (rclk_fall) begin
      seen_d = 1'b1;
    end
    // Read data is prepared in the setup phase.
    rdata_d = rdata_q;
    err_d = err_q;
    if (psel && !penable) begin
      err_d = 1'b0;
      case (paddr)
        REG_CTRL: rdata_d = {29'h0, ctrl_q};
        REG_STATUS: rdata_d = {28'h0, seen_q, ~f_valid, ~tx_ready_out, st_q == ST_RUN};
        REG_RXDATA: rdata_d = {30'h0, rxp_q};
        default: begin
          rdata_d = 32'h0;
          err_d = 1'b1;
        end
      endcase
    end
  end

  // Registers of the controller; receive pins pass two flip-flops.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= 8'h00;
      sclk_q <= 1'b0;
      wclk_q <= 1'b0;
      st_q <= ST_HOLD;
      cnt_q <= 3'h0;
      pair_q <= '0;
      ctrl_q <= CTRL_RESET;
      seen_q <= 1'b0;
      rxp_q <= 2'h0;
      rxv_q <= 1'b0;
      rdata_q <= 32'h0;
      err_q <= 1'b0;
      rs1_q <= 3'h0;
      rs2_q <= 3'h0;
      rclk_prev_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sclk_q <= sclk_d;
      wclk_q <= wclk_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      pair_q <= pair_d;
      ctrl_q <= ctrl_d;
      seen_q <= seen_d;
      rxp_q <= rxp_d;
      rxv_q <= rxv_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      rs1_q <= {link.rx_odd_bit_out, link.rx_even_bit_out, link.recovered_receive_clock};
      rs2_q <= rs1_q;
      rclk_prev_q <= rs2_q[0];
    end
  end

  // Link pins, all from flip-flops except the reset, which is decoded from the state.
  assign link.serial_bit_clock = sclk_q;
  assign link.parallel_write_clock = wclk_q;
  assign link.link_reset_b = (st_q != ST_HOLD);
  assign link.line_drive_enable = ctrl_q[CTRL_DRIVE];
  assign link.local_loop_select = ctrl_q[CTRL_LOCAL];
  assign link.far_loop_select = ctrl_q[CTRL_FAR];
  assign link.tx_pair = pair_q;
  // APB answers with no wait state.
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = err_q & psel & penable;
  assign rx_pair_out = rxp_q;
  assign rx_valid_out = rxv_q;
endmodule

// ### bench/dsl_link_monitor.sv
`timescale 1ns/1ns
// Watches the parallel link between the controller and the PHY.
module dsl_link_monitor
  import dsl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic serial_bit_clock,
  input wire logic parallel_write_clock,
  input wire logic link_reset_b,
  input wire logic line_drive_enable,
  input wire logic local_loop_select,
  input wire logic far_loop_select,
  input wire logic [PAIR_W-1:0] tx_pair,
  input wire logic rx_even_bit_out,
  input wire logic rx_odd_bit_out,
  input wire logic recovered_receive_clock
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [3:0] lo_q; // Write clock rises seen while the link reset is low.
  logic [3:0] hi_q; // Write clock rises seen since the link reset went high.
  logic [3:0] age_q; // Cycles since a mode change or the link reset was low, saturating at 15.
  // Counts write clock rises on each side of the link reset, and ages the mode.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_q <= 4'h0;
      hi_q <= 4'h0;
      age_q <= 4'h0;
    end else begin
      lo_q <= link_reset_b ? 4'h0 : (($rose(parallel_write_clock) && lo_q != 4'hf) ? lo_q + 4'h1 : lo_q);
      hi_q <= !link_reset_b ? 4'h0 : (($rose(parallel_write_clock) && hi_q != 4'hf) ? hi_q + 4'h1 : hi_q);
      // A mode change or link reset may move the receive bits off their clock edges.
      if (!link_reset_b || $changed(local_loop_select) || $changed(line_drive_enable) || $changed(far_loop_select)) begin
        age_q <= 4'h0;
      end else begin
        age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
      end
    end
  end
  AST_SER_HALF: assert property ($changed(serial_bit_clock) |=>
    $stable(serial_bit_clock)[*3] ##1 $changed(serial_bit_clock)) else $error("serial clock half period wrong");
  AST_WR_HALF: assert property ($changed(parallel_write_clock) |=>
    $stable(parallel_write_clock)[*7] ##1 $changed(parallel_write_clock)) else $error("write clock half period wrong");
  AST_WR_ON_SER: assert property ($changed(parallel_write_clock) |-> $rose(serial_bit_clock))
    else $error("write clock moved off a serial clock rise");
  AST_RST_HOLD: assert property ($rose(link_reset_b) |-> lo_q >= 4'h3)
    else $error("link reset released too early");
  AST_RST_SETUP: assert property ((tx_pair != 4'h0) |-> (link_reset_b && hi_q >= 4'h3))
    else $error("pair sent too soon after link reset");
  AST_PAIR_AT_FALL: assert property ($changed(tx_pair) && link_reset_b && $past(link_reset_b)
    |-> $fell(parallel_write_clock)) else $error("pair changed off a write clock fall");
  AST_RX_EVEN: assert property ($changed(rx_even_bit_out) && age_q == 4'hf |-> recovered_receive_clock)
    else $error("even bit changed outside the high phase");
  AST_RX_ODD: assert property ($changed(rx_odd_bit_out) && age_q == 4'hf |-> !recovered_receive_clock)
    else $error("odd bit changed outside the low phase");
  AST_RX_IN_RST: assert property ((!link_reset_b)[*6] |->
    (!rx_even_bit_out && !rx_odd_bit_out && !recovered_receive_clock)) else $error("receive bits set in reset");
endmodule

// ### bench/ds_link_two_bit_serdes_tb_top.sv
`timescale 1ns/1ns
// Joins both link ends and checks them through APB, the stream and the line pins.
module ds_link_two_bit_serdes_tb_top
  import dsl_pkg::*;
;
  typedef struct packed {logic [2:0] ctrl; logic [3:0] word; logic [1:0] exp;} dsl_row_s;
  logic clk_in = 1'b0;
  logic rst_b_in;
  logic psel, penable, pwrite, pready, pslverr, er, tx_valid_in, tx_ready_out, rx_valid_out, line_oe_out, cable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tx_pair_in, drv; // Stream word, and line inputs driven while the cable is off.
  wire logic [3:0] lo; // Line pins as data p, data n, strobe p, strobe n.
  logic [3:0] fl [3]; // Far loop line inputs.
  logic [3:0] fx [3]; // Line outputs they should give.
  logic [1:0] rx_pair_out;
  dsl_row_s rows [8]; // Ordinary cases: mode, pair word, received bits.
  wire logic [3:0] li;
  int error_cnt, samples_checked, cyc, n;
  // The cable loops the outputs back; released lines read 1 on both halves.
  assign li = cable ? (line_oe_out ? lo : 4'hf) : drv;
  dsl_link_if i_dsl_link_if ();
  dsl_phy i_dsl_phy (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(i_dsl_link_if.phy),
    .line_data_in_p(li[3]), .line_data_in_n(li[2]), .line_strobe_in_p(li[1]), .line_strobe_in_n(li[0]),
    .line_data_out_p(lo[3]), .line_data_out_n(lo[2]), .line_strobe_out_p(lo[1]), .line_strobe_out_n(lo[0]),
    .line_oe_out(line_oe_out));
  dsl_ctl i_dsl_ctl (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(i_dsl_link_if.ctl), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_pair_in(tx_pair_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .rx_pair_out(rx_pair_out), .rx_valid_out(rx_valid_out));
  dsl_link_monitor i_dsl_link_monitor (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .serial_bit_clock(i_dsl_link_if.serial_bit_clock), .parallel_write_clock(i_dsl_link_if.parallel_write_clock),
    .link_reset_b(i_dsl_link_if.link_reset_b), .line_drive_enable(i_dsl_link_if.line_drive_enable),
    .local_loop_select(i_dsl_link_if.local_loop_select), .far_loop_select(i_dsl_link_if.far_loop_select),
    .tx_pair(i_dsl_link_if.tx_pair), .rx_even_bit_out(i_dsl_link_if.rx_even_bit_out),
    .rx_odd_bit_out(i_dsl_link_if.rx_odd_bit_out), .recovered_receive_clock(i_dsl_link_if.recovered_receive_clock));
  // Free-running system clock.
  always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
  // Cuts a hung run short.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc_wait(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Offers one pair word and holds it until taken.
  task automatic push(input logic [3:0] w);
    @(posedge clk_in);
    tx_pair_in <= w;
    tx_valid_in <= 1'b1;
    do @(posedge clk_in); while (tx_ready_out !== 1'b1);
    tx_valid_in <= 1'b0;
  endtask
  initial begin
    {psel, penable, pwrite, tx_valid_in, rst_b_in} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_pair_in = 4'h0;
    drv = 4'hf;
    cable = 1'b1;
    // Words keep strobe so that the recovered clock rises on even and falls on odd.
    rows = '{'{3'h2, 4'h4, 2'h0}, '{3'h2, 4'h1, 2'h1}, '{3'h2, 4'he, 2'h2}, '{3'h2, 4'hb, 2'h3},
      '{3'h1, 4'h4, 2'h0}, '{3'h1, 4'h1, 2'h1}, '{3'h1, 4'he, 2'h2}, '{3'h1, 4'hb, 2'h3}};
    fl = '{4'h9, 4'h6, 4'h0};
    fx = '{4'h9, 4'h6, 4'ha};
    cyc_wait(16);
    rst_b_in <= 1'b1;
    cyc_wait(300);
    // Local loop rows first, then the looped cable with drivers on.
    foreach (rows[i]) begin
      apb(1'b1, REG_CTRL, {29'h0, rows[i].ctrl});
      cyc_wait(64);
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", rd, {29'h0, rows[i].ctrl});
      push(rows[i].word);
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (rx_valid_out !== 1'b1 && n < 300);
      // A pair that never arrives counts as a mismatch here.
      chk("rx_valid_out", rx_valid_out, 1'b1);
      chk("rx_pair_out", rx_pair_out, rows[i].exp);
      chk("rx_even_bit_out", i_dsl_link_if.rx_even_bit_out, rows[i].exp[0]);
      chk("rx_odd_bit_out", i_dsl_link_if.rx_odd_bit_out, rows[i].exp[1]);
      chk("line_oe_out", line_oe_out, rows[i].ctrl[0]);
    end
    // The link runs and the sticky pair flag is set; a write of one clears it.
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status running", rd[ST_READY], 1'b1);
    chk("status seen", rd[ST_SEEN], 1'b1);
    apb(1'b1, REG_STATUS, 32'h8);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status seen cleared", rd[ST_SEEN], 1'b0);
    // Unmapped offset is refused.
    apb(1'b0, 8'h0c, 32'h0);
    chk("pslverr", er, 1'b1);
    chk("prdata", rd, 32'h0);
    // Restart holds the link in reset, so the FIFO fills until it refuses.
    apb(1'b1, REG_CTRL, 32'h8);
    tx_pair_in <= 4'h4;
    tx_valid_in <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk_in);
      if (tx_ready_out === 1'b1) n++;
    end
    tx_valid_in <= 1'b0;
    chk("fifo words taken", n, TX_FIFO_DEPTH);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status full", rd[ST_FULL], 1'b1);
    n = 0;
    do begin
      cyc_wait(16);
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[ST_EMPTY] !== 1'b1 && n < 60);
    chk("status empty", rd[ST_EMPTY], 1'b1);
    // Far loop copies the line inputs; equal halves read as 1.
    apb(1'b1, REG_CTRL, 32'h5);
    cable <= 1'b0;
    foreach (fl[k]) begin
      drv <= fl[k];
      cyc_wait(8);
      chk("line outputs", lo, fx[k]);
    end
    apb(1'b1, REG_CTRL, 32'h4);
    cyc_wait(8);
    chk("line_oe_out", line_oe_out, 1'b0);
    // Reset in mid-run clears the link and the control register.
    rst_b_in <= 1'b0;
    cyc_wait(4);
    chk("link_reset_b", i_dsl_link_if.link_reset_b, 1'b0);
    chk("line_oe_out", line_oe_out, 1'b0);
    rst_b_in <= 1'b1;
    cyc_wait(2);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl after reset", rd, {29'h0, CTRL_RESET});
    cyc_wait(300);
    give_verdict();
  end
endmodule
